// ==== rtl/pci_device.sv ====
// input module end: pulse capture and interrupt hold per channel
`timescale 1ns/10ps
module pci_device
   import pci_pkg::*;
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     nrst,
   // field side
   input  wire logic [pci_pkg::NUM_CH-1:0] field_in,
   input  wire logic                     mode_select_switch,
   // backplane
   pci_if.device                         bus
);
   import pci_pkg::*;

   // registered mode and the fixed position words
   logic              mode_r;
   logic              mode_nxt;
   logic [4:0]        cap_base_r;
   logic [4:0]        cap_base_nxt;
   logic [4:0]        int_base_r;
   logic [4:0]        int_base_nxt;
   // per point flags gathered for the backplane
   wire  [NUM_CH-1:0] cap_w;
   wire  [NUM_CH-1:0] hold_w;

   always_comb
   begin
      mode_nxt     = mode_select_switch;
      cap_base_nxt = CAP_POS_BASE;
      int_base_nxt = INT_POS_BASE;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_r     <= MODE_RESET;
         cap_base_r <= CAP_POS_BASE;
         int_base_r <= INT_POS_BASE;
      end
      else
      begin
         mode_r     <= mode_nxt;
         cap_base_r <= cap_base_nxt;
         int_base_r <= int_base_nxt;
      end
   end

   // per point logic follows the switch itself, so the other mode's
   // flags fall at the same edge at which the registered mode changes
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         // input synchroniser and edge
         logic             s1_r;
         logic             s1_nxt;
         logic             s2_r;
         logic             s2_nxt;
         logic             s3_r;
         logic             s3_nxt;
         logic             rise;

         // capture state
         logic             cap_r;
         logic             cap_nxt;
         logic             seen_r;
         logic             seen_nxt;
         logic [CNT_W-1:0] wid_r;
         logic [CNT_W-1:0] wid_nxt;

         // interrupt hold state
         logic             hold_r;
         logic             hold_nxt;
         logic [CNT_W-1:0] tmr_r;
         logic [CNT_W-1:0] tmr_nxt;

         always_comb
         begin
            // only stage two reads stage one
            s1_nxt = field_in[g];
            s2_nxt = s1_r;
            s3_nxt = s2_r;
            rise   = s2_r & ~s3_r;
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
            end
            else
            begin
               s1_r <= s1_nxt;
               s2_r <= s2_nxt;
               s3_r <= s3_nxt;
            end
         end

         always_comb
         begin
            wid_nxt  = '0;
            cap_nxt  = 1'b0;
            seen_nxt = 1'b0;

            if (mode_nxt == PCI_MODE_CAPTURE)
            begin
               cap_nxt  = cap_r;
               seen_nxt = seen_r;

               // width count saturates so a long high never wraps
               if (s2_r && wid_r != CNT_W'(MIN_PULSE_CYC))
                  wid_nxt = wid_r + 1'b1;
               else if (s2_r)
                  wid_nxt = wid_r;

               if (!s2_r)
                  seen_nxt = 1'b0;

               if (bus.refresh)
                  cap_nxt = 1'b0;

               // set at 50 us width, set wins
               if (s2_r && !seen_r &&
                   wid_r == CNT_W'(MIN_PULSE_CYC - 1))
               begin
                  cap_nxt  = 1'b1;
                  seen_nxt = 1'b1;
               end
            end
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               wid_r  <= '0;
               cap_r  <= 1'b0;
               seen_r <= 1'b0;
            end
            else
            begin
               wid_r  <= wid_nxt;
               cap_r  <= cap_nxt;
               seen_r <= seen_nxt;
            end
         end

         always_comb
         begin
            hold_nxt = 1'b0;
            tmr_nxt  = '0;

            if (mode_nxt == PCI_MODE_INTR)
            begin
               if (hold_r)
               begin
                  // window ends after exactly the hold count
                  if (tmr_r != CNT_W'(HOLD_CYC - 1))
                  begin
                     hold_nxt = 1'b1;
                     tmr_nxt  = tmr_r + 1'b1;
                  end
               end
               // a rise inside the window is dropped, not queued
               else if (rise)
                  hold_nxt = 1'b1;
            end
         end

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               hold_r <= 1'b0;
               tmr_r  <= '0;
            end
            else
            begin
               hold_r <= hold_nxt;
               tmr_r  <= tmr_nxt;
            end
         end

         assign cap_w[g]  = cap_r;
         assign hold_w[g] = hold_r;
      end
   endgenerate

   assign bus.cap_data  = cap_w;
   assign bus.cap_base  = cap_base_r;
   assign bus.int_req   = hold_w;
   assign bus.int_base  = int_base_r;
   assign bus.intr_mode = mode_r;
endmodule : pci_device

// ==== rtl/pci_pkg.sv ====
// constants and types shared by the pulse catch / interrupt input ends
package pci_pkg;
   localparam int unsigned NUM_CH      = 4;
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned MIN_PULSE_US = 50;
   localparam int unsigned HOLD_US     = 512;
   // least pulse: rounds down
   localparam int unsigned MIN_PULSE_CYC =
      (MIN_PULSE_US * (CLK_HZ / 1_000_000));
   // hold window: longest time rounds down
   localparam int unsigned HOLD_CYC = (HOLD_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CNT_W = 14;
   localparam logic        MODE_RESET = 1'b0;
   localparam logic [4:0]  CAP_POS_BASE = 5'h11;
   localparam logic [4:0]  INT_POS_BASE = 5'h01;
   localparam int unsigned SCAN_CYC    = 50_000;
   typedef enum logic {PCI_MODE_CAPTURE, PCI_MODE_INTR} pci_mode_t;
   typedef enum logic [1:0] {PCI_IDLE, PCI_WAIT, PCI_SCAN} pci_st_t;
endpackage : pci_pkg

// ==== rtl/pci_if.sv ====
// backplane link between input module and controller
`timescale 1ns/10ps
interface pci_if;
   logic [3:0] cap_data;
   logic [4:0] cap_base;
   logic [3:0] int_req;
   logic [4:0] int_base;
   logic       refresh;
   logic       intr_mode;
   modport device (output cap_data, cap_base, int_req, int_base, intr_mode,
                   input refresh);
   modport ctrl   (input cap_data, cap_base, int_req, int_base, intr_mode,
                   output refresh);
endinterface : pci_if

// ==== rtl/pci_ctrl.sv ====
// controller end: periodic refresh read and interrupt edge detect
`timescale 1ns/10ps
module pci_ctrl
   import pci_pkg::*;
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       nrst,
   // user side
   output logic [pci_pkg::NUM_CH-1:0]      inputs_q,
   output logic                            inputs_vld,
   output logic [pci_pkg::NUM_CH-1:0]      irq_pulse,
   // backplane
   pci_if.ctrl                             bus
);
   import pci_pkg::*;

   logic [15:0]       scan_r, scan_nxt;
   logic              ref_r, ref_nxt;
   logic [NUM_CH-1:0] q_r, q_nxt, irq_r, irq_nxt, last_r, last_nxt;
   logic              vld_r, vld_nxt;

   always_comb
   begin
      ref_nxt  = 1'b0;
      scan_nxt = scan_r + 1'b1;
      q_nxt    = q_r;
      vld_nxt  = 1'b0;
      if (scan_r == 16'(SCAN_CYC - 1))
      begin
         scan_nxt = '0;
         ref_nxt  = 1'b1;
      end
      // read in the refresh cycle so a capture held before the refresh edge is read before
      // the device clears it; one landing on that edge is kept (set wins) and read next refresh
      if (ref_r)
      begin
         q_nxt   = bus.cap_data;
         vld_nxt = 1'b1;
      end
      last_nxt = bus.int_req;
      irq_nxt  = bus.intr_mode ? (bus.int_req & ~last_r) : '0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scan_r <= '0;
         ref_r  <= 1'b0;
         q_r    <= '0;
         vld_r  <= 1'b0;
         irq_r  <= '0;
         last_r <= '0;
      end
      else
      begin
         scan_r <= scan_nxt;
         ref_r  <= ref_nxt;
         q_r    <= q_nxt;
         vld_r  <= vld_nxt;
         irq_r  <= irq_nxt;
         last_r <= last_nxt;
      end
   end

   assign bus.refresh = ref_r;
   assign inputs_q    = q_r;
   assign inputs_vld  = vld_r;
   assign irq_pulse   = irq_r;
endmodule : pci_ctrl

// ==== sim/pci_asserts.sv ====
// checker on the backplane link between the two ends
`timescale 1ns/10ps
module pci_asserts
   import pci_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // link signals
   input wire logic [3:0] cap_data,
   input wire logic [4:0] cap_base,
   input wire logic [3:0] int_req,
   input wire logic [4:0] int_base,
   input wire logic       refresh,
   input wire logic       intr_mode
);
   import pci_pkg::*;
   logic [13:0] hold_r;
   logic [13:0] hold_nxt;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // counts high cycles of channel 2 hold window
   always_comb hold_nxt = int_req[2] ? hold_r + 14'h1 : 14'h0;
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         hold_r <= 14'h0;
      else
         hold_r <= hold_nxt;
   property p_cap_base; cap_base == 5'h11; endproperty
   a_cap_base: assert property (p_cap_base)
      else $error("capture base wrong");
   property p_int_base; int_base == 5'h01; endproperty
   a_int_base: assert property (p_int_base)
      else $error("interrupt base wrong");
   property p_int_mode; int_req != 4'h0 |-> intr_mode; endproperty
   a_int_mode: assert property (p_int_mode)
      else $error("hold window outside interrupt mode");
   property p_refresh; refresh |=> !refresh [*8]; endproperty
   a_refresh: assert property (p_refresh)
      else $error("refresh not a lone pulse");
   property p_cap_clear;
      refresh && !intr_mode |=> (cap_data & $past(cap_data)) == 4'h0;
   endproperty
   a_cap_clear: assert property (p_cap_clear)
      else $error("capture not cleared by refresh");
   property p_cap_hold;
      |(~cap_data & $past(cap_data)) |-> $past(refresh) || intr_mode;
   endproperty
   a_cap_hold: assert property (p_cap_hold)
      else $error("capture dropped without refresh");
   property p_int_len;
      $fell(int_req[2]) && intr_mode |-> hold_r == HOLD_CYC;
   endproperty
   a_int_len: assert property (p_int_len)
      else $error("hold window length wrong");
   property p_int_max; hold_r <= HOLD_CYC; endproperty
   a_int_max: assert property (p_int_max)
      else $error("hold window retriggered");
endmodule : pci_asserts

// ==== sim/tb.sv ====
// testbench joining device and controller ends
`timescale 1ns/10ps
module tb;
   import pci_pkg::*;
   logic       clk = 1'b0;
   logic       nrst = 1'b0;
   logic [3:0] field_in = 4'h0;
   logic       mode_select_switch = 1'b0;
   logic [3:0] inputs_q;
   logic [3:0] irq_pulse;
   logic       inputs_vld;
   int         bad_count = 0;
   int         n_tests = 0;
   int         irq_n = 0;
   pci_if i_pci_if ();
   pci_device i_pci_device (.clk(clk), .nrst(nrst), .field_in(field_in),
      .mode_select_switch(mode_select_switch), .bus(i_pci_if));
   pci_ctrl i_pci_ctrl (.clk(clk), .nrst(nrst), .inputs_q(inputs_q),
      .inputs_vld(inputs_vld), .irq_pulse(irq_pulse), .bus(i_pci_if));
   pci_asserts i_pci_asserts (.clk(clk), .nrst(nrst),
      .cap_data(i_pci_if.cap_data), .cap_base(i_pci_if.cap_base),
      .int_req(i_pci_if.int_req), .int_base(i_pci_if.int_base),
      .refresh(i_pci_if.refresh), .intr_mode(i_pci_if.intr_mode));
   always #20 clk = ~clk;
   always @(negedge clk)
      if (irq_pulse[2] === 1'b1)
         irq_n <= irq_n + 1;
   task summarize;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task check(input string name, input logic [4:0] exp, logic [4:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s exp %h got %h", name, exp, got);
         bad_count++;
      end
   endtask : check
   // drives a field pulse of n cycles on the channels in m
   task pulse(input logic [3:0] m, input int n);
      field_in = m;
      repeat (n) @(negedge clk);
      field_in = 4'h0;
      @(negedge clk);
   endtask : pulse
   task wait_vld;
      int i;
      for (i = 0; i < 60000 && inputs_vld !== 1'b1; i++)
         @(negedge clk);
      if (inputs_vld !== 1'b1)
      begin
         $display("CHECK FAILED inputs_vld exp 1 got %b", inputs_vld);
         bad_count++;
      end
   endtask : wait_vld
   initial
   begin
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      check("cap_base", 5'h11, i_pci_if.cap_base);
      check("int_base", 5'h01, i_pci_if.int_base);
      mode_select_switch = 1'b1;
      repeat (3) @(negedge clk);
      pulse(4'h4, 5);
      repeat (50) @(negedge clk);
      check("int_req", 5'h04, {1'b0, i_pci_if.int_req});
      pulse(4'h4, 5);
      repeat (25000) @(negedge clk);
      check("int_req end", 5'h00, {1'b0, i_pci_if.int_req});
      check("irq count", 5'h01, 5'(irq_n));
      pulse(4'h4, 5);
      repeat (10) @(negedge clk);
      check("irq again", 5'h02, 5'(irq_n));
      mode_select_switch = 1'b0;
      repeat (13000) @(negedge clk);
      pulse(4'h9, 1300);
      pulse(4'h2, 1000);
      pulse(4'h4, 5);
      wait_vld();
      check("inputs_q", 5'h09, {1'b0, inputs_q});
      check("irq capture", 5'h02, 5'(irq_n));
      summarize();
   end
endmodule : tb
